// file: hdl/oscillator_select_control.sv
`timescale 1ns/1ps
// What this block does
// [R01] Registers reached only by byte reads and writes on peripheral four.
// [R02] General bit 0 picks crystal (0) or on-silicon (1); resets to strap.
// [R03] General bit 1, reset 0, makes source change reset the tile.
// [R04] On-silicon bit 1, reset 0, picks fast 20 MHz or slow 31,250 Hz.
// [R05] On-silicon bit 0, reset 1; clearing stops that oscillator.
// [R06] Crystal bit 1, reset 1; clearing turns off the crystal bias.
// [R07] Crystal bit 0, reset 1; clearing stops the crystal oscillator.
// [R08] Bits 7:2 reserved, read as zero, writes ignored.
// [R09] Triggered tile reset holds until the new clock has settled.
module oscillator_select_control #(
   parameter int settle_count = osc_select_pkg::settle_cycles
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic source_strap,
   input wire logic periph_sel,
   input wire logic [7:0] periph_id,
   input wire logic periph_wr,
   input wire logic periph_rd,
   input wire logic periph_byte,
   input wire logic [osc_select_pkg::addr_width-1:0] periph_addr,
   input wire logic [osc_select_pkg::data_width-1:0] periph_wdata,
   output logic [osc_select_pkg::data_width-1:0] periph_rdata,
   output logic periph_ack,
   output logic periph_err,
   output logic source_select,
   output logic internal_osc_enable,
   output logic internal_osc_slow,
   output logic crystal_osc_enable,
   output logic crystal_bias_enable,
   output logic tile_reset
);
   // ==========================================================
   // Access decode
   // ==========================================================
   logic hit;
   logic acc_ok;
   logic wr_ok;
   logic rd_ok;
   logic strap_pending_reg;
   logic strap_pending_next;

   // Only byte accesses aimed at this peripheral are accepted
   assign hit = periph_sel && (periph_id == osc_select_pkg::periph_id_osc); // see [R01]
   assign acc_ok = hit && periph_byte; // see [R01]
   assign wr_ok = acc_ok && periph_wr;
   assign rd_ok = acc_ok && periph_rd;

   function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
      addr_is = (a == off);
   endfunction

   // ==========================================================
   // Control registers
   // ==========================================================
   logic source_reg, source_next;
   logic reset_on_change_reg, reset_on_change_next;
   logic internal_slow_reg, internal_slow_next;
   logic internal_en_reg, internal_en_next;
   logic crystal_bias_reg, crystal_bias_next;
   logic crystal_en_reg, crystal_en_next;

   // Writes touch only bits 1:0; upper bits have no storage
   always_comb begin
      source_next = source_reg;
      reset_on_change_next = reset_on_change_reg;
      internal_slow_next = internal_slow_reg;
      internal_en_next = internal_en_reg;
      crystal_bias_next = crystal_bias_reg;
      crystal_en_next = crystal_en_reg;
      strap_pending_next = 1'b0;
      if (strap_pending_reg) begin
         // Strap caught on the first clock after reset release
         source_next = source_strap; // see [R02]
      end else if (wr_ok) begin
         if (addr_is(periph_addr, osc_select_pkg::off_general_control)) begin
            source_next = periph_wdata[osc_select_pkg::bit_source_select]; // see [R02]
            reset_on_change_next = periph_wdata[osc_select_pkg::bit_reset_on_change]; // see [R03]
         end
         if (addr_is(periph_addr, osc_select_pkg::off_internal_osc)) begin
            internal_slow_next = periph_wdata[osc_select_pkg::bit_internal_slow]; // see [R04]
            internal_en_next = periph_wdata[osc_select_pkg::bit_internal_enable]; // see [R05]
         end
         if (addr_is(periph_addr, osc_select_pkg::off_crystal_osc)) begin
            crystal_bias_next = periph_wdata[osc_select_pkg::bit_crystal_bias]; // see [R06]
            crystal_en_next = periph_wdata[osc_select_pkg::bit_crystal_enable]; // see [R07]
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         strap_pending_reg <= 1'b1;
         source_reg <= 1'b0;
         reset_on_change_reg <= osc_select_pkg::rst_reset_on_change; // see [R03]
         internal_slow_reg <= osc_select_pkg::rst_internal_slow; // see [R04]
         internal_en_reg <= osc_select_pkg::rst_internal_enable; // see [R05]
         crystal_bias_reg <= osc_select_pkg::rst_crystal_bias; // see [R06]
         crystal_en_reg <= osc_select_pkg::rst_crystal_enable; // see [R07]
      end else begin
         strap_pending_reg <= strap_pending_next;
         source_reg <= source_next;
         reset_on_change_reg <= reset_on_change_next;
         internal_slow_reg <= internal_slow_next;
         internal_en_reg <= internal_en_next;
         crystal_bias_reg <= crystal_bias_next;
         crystal_en_reg <= crystal_en_next;
      end
   end

   assign source_select = source_reg;
   assign internal_osc_enable = internal_en_reg;
   assign internal_osc_slow = internal_slow_reg;
   assign crystal_osc_enable = crystal_en_reg;
   assign crystal_bias_enable = crystal_bias_reg;

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] rdata_reg, rdata_next;
   logic ack_reg, ack_next;
   logic err_reg, err_next;

   // Reserved bits read as zero; unmapped offsets read zero with error
   always_comb begin
      rdata_next = osc_select_pkg::reserved_read; // see [R08]
      ack_next = acc_ok && (periph_wr || periph_rd);
      err_next = hit && (periph_wr || periph_rd) && (!periph_byte || periph_addr > osc_select_pkg::off_crystal_osc);
      if (rd_ok) begin
         if (addr_is(periph_addr, osc_select_pkg::off_general_control)) begin
            rdata_next[osc_select_pkg::bit_source_select] = source_reg;
            rdata_next[osc_select_pkg::bit_reset_on_change] = reset_on_change_reg;
         end
         if (addr_is(periph_addr, osc_select_pkg::off_internal_osc)) begin
            rdata_next[osc_select_pkg::bit_internal_slow] = internal_slow_reg;
            rdata_next[osc_select_pkg::bit_internal_enable] = internal_en_reg;
         end
         if (addr_is(periph_addr, osc_select_pkg::off_crystal_osc)) begin
            rdata_next[osc_select_pkg::bit_crystal_bias] = crystal_bias_reg;
            rdata_next[osc_select_pkg::bit_crystal_enable] = crystal_en_reg;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= osc_select_pkg::reserved_read;
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         err_reg <= err_next;
      end
   end

   assign periph_rdata = rdata_reg;
   assign periph_ack = ack_reg;
   assign periph_err = err_reg;

   // ==========================================================
   // Tile reset sequencer
   // ==========================================================
   osc_select_pkg::tile_state_t state_reg, state_next;
   logic change_trigger;
   logic timer_load;
   logic timer_done;
   logic tile_reset_reg, tile_reset_next;

   // Software change only; the strap capture is not a change
   assign change_trigger = !strap_pending_reg && reset_on_change_reg && (source_next != source_reg); // see [R03]
   assign timer_load = change_trigger;

   // A new change during the wait restarts the settle time
   always_comb begin
      state_next = state_reg;
      tile_reset_next = tile_reset_reg;
      case (state_reg)
         osc_select_pkg::st_run: begin
            if (change_trigger) begin
               state_next = osc_select_pkg::st_hold;
               tile_reset_next = 1'b1; // see [R03]
            end
         end
         osc_select_pkg::st_hold: begin
            state_next = osc_select_pkg::st_settle;
         end
         osc_select_pkg::st_settle: begin
            if (timer_done) begin
               state_next = osc_select_pkg::st_run;
               tile_reset_next = 1'b0; // see [R09]
            end
         end
         default: begin
            state_next = osc_select_pkg::st_run;
            tile_reset_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= osc_select_pkg::st_run;
         tile_reset_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         tile_reset_reg <= tile_reset_next;
      end
   end

   assign tile_reset = tile_reset_reg;

   settle_timer #(
      .count_width(16)
   ) u_settle (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(timer_load),
      .load_value(16'(settle_count)), // see [R09]
      .done(timer_done)
   );
endmodule

// file: shared/osc_select_pkg.sv
package osc_select_pkg;
   // ==========================================================
   // Peripheral access
   // ==========================================================
   localparam logic [7:0] periph_id_osc = 8'h04;
   localparam int addr_width = 8;
   localparam int data_width = 8;

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [7:0] off_general_control = 8'h00;
   localparam logic [7:0] off_internal_osc = 8'h01;
   localparam logic [7:0] off_crystal_osc = 8'h02;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int bit_source_select = 0;
   localparam int bit_reset_on_change = 1;
   localparam int bit_internal_enable = 0;
   localparam int bit_internal_slow = 1;
   localparam int bit_crystal_enable = 0;
   localparam int bit_crystal_bias = 1;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic rst_reset_on_change = 1'h0;
   localparam logic rst_internal_slow = 1'h0;
   localparam logic rst_internal_enable = 1'h1;
   localparam logic rst_crystal_bias = 1'h1;
   localparam logic rst_crystal_enable = 1'h1;
   localparam logic [7:0] reserved_read = 8'h00;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int clk_period_ns = 8;
   localparam int settle_time_ns = 2000;
   localparam int settle_cycles = (settle_time_ns + clk_period_ns - 1) / clk_period_ns;

   // Tile reset sequencer states
   typedef enum logic [1:0] {
      st_run = 2'b00,
      st_hold = 2'b01,
      st_settle = 2'b10
   } tile_state_t;
endpackage

// file: hdl/settle_timer.sv
`timescale 1ns/1ps
// ==========================================================
// Down counter for clock settle time
// ==========================================================
module settle_timer #(
   parameter int count_width = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [count_width-1:0] load_value,
   output logic done
);
   logic [count_width-1:0] count_reg;
   logic [count_width-1:0] count_next;

   // Load wins over counting so a new change restarts the wait
   always_comb begin
      count_next = count_reg;
      if (load) begin
         count_next = load_value;
      end else if (count_reg != '0) begin
         count_next = count_reg - count_width'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign done = (count_reg == '0) && !load;
endmodule

// file: verification/osc_select_chk.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for oscillator control
// ==========================================
module osc_select_chk #(
   parameter int settle_count = 4
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic periph_sel,
   input wire logic [7:0] periph_id,
   input wire logic periph_wr,
   input wire logic periph_rd,
   input wire logic periph_byte,
   input wire logic [7:0] periph_addr,
   input wire logic [7:0] periph_wdata,
   input wire logic [7:0] periph_rdata,
   input wire logic periph_ack,
   input wire logic periph_err,
   input wire logic source_select,
   input wire logic internal_osc_enable,
   input wire logic internal_osc_slow,
   input wire logic crystal_osc_enable,
   input wire logic crystal_bias_enable,
   input wire logic tile_reset
);
   // Slack over the settle count for the handoff cycles
   localparam int max_hold = settle_count + 8;
   logic req;
   logic wr_byte;
   logic [7:0] wdata_q;
   // Access aimed at this peripheral
   assign req = periph_sel && periph_id == 8'h04 && (periph_wr || periph_rd);
   assign wr_byte = req && periph_byte && periph_wr;
   // Write data one cycle late, to compare with the updated controls
   always_ff @(posedge sys_clk) begin
      wdata_q <= periph_wdata;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_ack; req && periph_byte |=> periph_ack; endproperty
   a_ack: assert property (p_ack) else $error("byte access not acknowledged");
   property p_wide; req && !periph_byte |=> periph_err && !periph_ack; endproperty
   a_wide: assert property (p_wide) else $error("wide access not refused");
   property p_other; periph_sel && periph_id != 8'h04 |=> !periph_ack && !periph_err; endproperty
   a_other: assert property (p_other) else $error("answer to other peripheral");
   property p_rsvd; periph_ack |-> periph_rdata[7:2] == 6'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
   property p_src; wr_byte && periph_addr == 8'h00 |=> source_select == wdata_q[0]; endproperty
   a_src: assert property (p_src) else $error("source select not written");
   property p_int; wr_byte && periph_addr == 8'h01 |=> {internal_osc_slow, internal_osc_enable} == wdata_q[1:0];
   endproperty
   a_int: assert property (p_int) else $error("on-silicon controls not written");
   property p_xtal; wr_byte && periph_addr == 8'h02 |=> {crystal_bias_enable, crystal_osc_enable} == wdata_q[1:0];
   endproperty
   a_xtal: assert property (p_xtal) else $error("crystal controls not written");
   property p_keep; !(wr_byte && periph_addr == 8'h01) |=> $stable(internal_osc_slow); endproperty
   a_keep: assert property (p_keep) else $error("speed changed without write");
   property p_trig; $rose(tile_reset) |-> $changed(source_select); endproperty
   a_trig: assert property (p_trig) else $error("tile reset without source change");
   property p_hold; $rose(tile_reset) |-> tile_reset [*3] ##[1:max_hold] !tile_reset; endproperty
   a_hold: assert property (p_hold) else $error("tile reset hold out of range");
   c_trig: cover property ($rose(tile_reset));
   c_err: cover property (periph_ack && periph_err);
   c_slow: cover property ($rose(internal_osc_slow));
endmodule

bind oscillator_select_control osc_select_chk #(.settle_count(settle_count)) chk_i (
   .sys_clk(sys_clk), .rst(rst), .periph_sel(periph_sel), .periph_id(periph_id), .periph_wr(periph_wr),
   .periph_rd(periph_rd), .periph_byte(periph_byte), .periph_addr(periph_addr), .periph_wdata(periph_wdata),
   .periph_rdata(periph_rdata), .periph_ack(periph_ack), .periph_err(periph_err), .source_select(source_select),
   .internal_osc_enable(internal_osc_enable), .internal_osc_slow(internal_osc_slow),
   .crystal_osc_enable(crystal_osc_enable), .crystal_bias_enable(crystal_bias_enable), .tile_reset(tile_reset));

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic source_strap = 1'b1;
   logic periph_sel = 1'b0;
   logic [7:0] periph_id = 8'h04;
   logic periph_wr = 1'b0;
   logic periph_rd = 1'b0;
   logic periph_byte = 1'b1;
   logic [7:0] periph_addr = 8'h00;
   logic [7:0] periph_wdata = 8'h00;
   logic [7:0] periph_rdata;
   logic periph_ack, periph_err, source_select, internal_osc_enable, internal_osc_slow;
   logic crystal_osc_enable, crystal_bias_enable, tile_reset, seen_ack, seen_err;
   logic [7:0] seen_data;
   int n_errors = 0;
   int comparisons = 0;
   int cnt;
   // Short settle count keeps the tile reset hold brief
   oscillator_select_control #(.settle_count(4)) oscillator_select_control_i (
      .sys_clk(sys_clk), .rst(rst), .source_strap(source_strap), .periph_sel(periph_sel), .periph_id(periph_id),
      .periph_wr(periph_wr), .periph_rd(periph_rd), .periph_byte(periph_byte), .periph_addr(periph_addr),
      .periph_wdata(periph_wdata), .periph_rdata(periph_rdata), .periph_ack(periph_ack), .periph_err(periph_err),
      .source_select(source_select), .internal_osc_enable(internal_osc_enable),
      .internal_osc_slow(internal_osc_slow), .crystal_osc_enable(crystal_osc_enable),
      .crystal_bias_enable(crystal_bias_enable), .tile_reset(tile_reset));
   // ==========================================
   // Clock and helpers
   // ==========================================
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // One access, held over one rising edge; answer sampled a cycle later
   task acc(input logic w, input logic [7:0] id, input logic byt, input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      periph_sel = 1'b1;
      periph_id = id;
      periph_wr = w;
      periph_rd = !w;
      periph_byte = byt;
      periph_addr = a;
      periph_wdata = d;
      @(negedge sys_clk);
      seen_data = periph_rdata;
      seen_ack = periph_ack;
      seen_err = periph_err;
      periph_sel = 1'b0;
      periph_wr = 1'b0;
      periph_rd = 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, 8'h04, 1'b1, a, 8'h00);
      check({seen_ack, seen_err, seen_data}, {2'h2, exp});
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 8'h04, 1'b1, a, d);
      check({seen_ack, seen_err}, 2'h2);
   endtask
   task final_report;
      $display("errors=%0d comparisons=%0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // Tests
   // ==========================================
   initial begin
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      check({source_select, internal_osc_slow}, 2'h2);
      check({internal_osc_enable, crystal_osc_enable, crystal_bias_enable, tile_reset}, 4'he);
      rd(8'h00, 8'h01);
      rd(8'h01, 8'h01);
      rd(8'h02, 8'h03);
      // Crystal stops only while the tile runs from the on-silicon source
      wr(8'h02, 8'hfc);
      check({crystal_bias_enable, crystal_osc_enable}, 2'h0);
      rd(8'h02, 8'h00);
      wr(8'h02, 8'h03);
      // Change without the reset request must leave the tile running
      wr(8'h00, 8'h00);
      check({source_select, tile_reset}, 2'h0);
      // On-silicon stops only once the crystal drives the tile
      wr(8'h01, 8'hfe);
      check({internal_osc_slow, internal_osc_enable}, 2'h2);
      rd(8'h01, 8'h02);
      // Restart it before switching back to it
      wr(8'h01, 8'h03);
      check({internal_osc_slow, internal_osc_enable}, 2'h3);
      wr(8'h00, 8'h02);
      wr(8'h00, 8'h03);
      check({source_select, tile_reset}, 2'h3);
      cnt = 0;
      while (tile_reset === 1'b1 && cnt < 50) begin
         @(negedge sys_clk);
         cnt++;
      end
      check(cnt >= 4 && cnt <= 8, 1'b1);
      rd(8'h00, 8'h03);
      // Refusals: wide access, other peripheral, unmapped offset
      acc(1'b1, 8'h04, 1'b0, 8'h00, 8'h00);
      check({seen_ack, seen_err, source_select}, 3'h3);
      acc(1'b1, 8'h03, 1'b1, 8'h01, 8'h00);
      check({seen_ack, seen_err, internal_osc_slow}, 3'h1);
      acc(1'b0, 8'h04, 1'b1, 8'h03, 8'h00);
      check({seen_ack, seen_err, seen_data}, 10'h300);
      // Second reset mid-run with the strap low; crystal must be chosen
      @(negedge sys_clk);
      source_strap = 1'b0;
      rst = 1'b1;
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      check({source_select, internal_osc_slow, tile_reset}, 3'h0);
      rd(8'h00, 8'h00);
      final_report;
   end
   // Whole run is well under a microsecond per access
   initial begin
      #100000;
      n_errors++;
      final_report;
   end
endmodule
